//--- accel_core.sv
// Accelerometer digital core: power modes, trim, data path, sample
// buffer, low power and auto-sleep, I2C register slave.
// Assumes converter, trim and event inputs on ref_clk; pins async.
`timescale 1ns/1ps
`default_nettype none
`include "accel_regs.svh"

module sample_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  logic push;
  logic pop;

  assign out_valid = (cnt_ff != '0);
  assign in_ready = (cnt_ff != CW'(DEPTH)) || out_ready;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];
  assign count = cnt_ff;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else if (flush)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

module accel_core #(
  parameter int SLEEP_TICK_CYC = `SLEEP_TICK_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Enable pin
  input wire logic en_pin,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Factory trim from nonvolatile store
  input wire logic trim_valid,
  input wire logic signed [11:0] trim_off_x,
  input wire logic signed [11:0] trim_off_y,
  input wire logic signed [11:0] trim_off_z,
  input wire logic signed [7:0] trim_gain_x,
  input wire logic signed [7:0] trim_gain_y,
  input wire logic signed [7:0] trim_gain_z,
  // Converter samples, 1g/1024 per count
  input wire logic raw_valid,
  input wire logic signed [13:0] raw_x,
  input wire logic signed [13:0] raw_y,
  input wire logic signed [13:0] raw_z,
  // Tap, orient, motion one, motion two, transient
  input wire logic [4:0] wake_evt,
  // Power and rate control, buffer flags
  output logic analog_en,
  output logic digital_en,
  output logic low_power,
  output logic sleeping,
  output logic [2:0] odr_sel,
  output logic buf_wmrk,
  output logic buf_ovf
);
  import accel_pkg::*;
  localparam int FW = 3 * `SMP_W;

  logic en_s1_ff, en_s2_ff, scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic off, to_active, scl_rise, scl_fall, i2c_start, i2c_stop;
  pwr_mode_t pwr_ff, nxt_pwr;
  logic analog_en_ff, digital_en_ff, low_power_ff, sleep_ff;
  logic [2:0] odr_sel_ff;
  logic buf_wmrk_ff, buf_ovf_ff, slp_edge_ff;
  logic [7:0] ctrl1_ff, ctrl2_ff, ctrl3_ff, bufcfg_ff, aslp_ff;
  logic [7:0] uoff_ff [6];
  i2c_st_t st_ff, ret_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff, tx_ff, ptr_ff, rd_data, nxt_ptr;
  logic nack_ff, sda_oe_ff, wr_stb_ff, host_pop_ff;
  logic [7:0] wr_addr_ff, wr_data_ff;
  logic trim_ok_ff, smp_new_ff;
  logic signed [11:0] toff_ff [3];
  logic signed [7:0] gain_ff [3];
  logic signed [13:0] raw_a [3];
  logic signed [11:0] corr [3];
  logic signed [11:0] smp_ff [3];
  logic [11:0] view [3];
  buf_mode_t mode;
  logic fifo_in_vld, fifo_in_rdy, fifo_out_vld, fifo_out_rdy, flush;
  logic [FW-1:0] fifo_head;
  logic [5:0] fifo_cnt;
  logic [5:0] wm;
  logic wake_hit, keep_awake, tick;
  logic [23:0] tick_ff;
  logic [7:0] slp_cnt_ff;

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_ff;
  assign analog_en = analog_en_ff;
  assign digital_en = digital_en_ff;
  assign low_power = low_power_ff;
  assign sleeping = sleep_ff;
  assign odr_sel = odr_sel_ff;
  assign buf_wmrk = buf_wmrk_ff;
  assign buf_ovf = buf_ovf_ff;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers and power mode

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {en_s1_ff, en_s2_ff} <= 2'h0;
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
    end
    else
    begin
      {en_s1_ff, en_s2_ff} <= {en_pin, en_s1_ff};
      {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
    end
  end

  assign off = !en_s2_ff;
  assign scl_rise = scl_s2_ff && !scl_s3_ff;
  assign scl_fall = !scl_s2_ff && scl_s3_ff;
  assign i2c_start = scl_s2_ff && scl_s3_ff && !sda_s2_ff && sda_s3_ff;
  assign i2c_stop = scl_s2_ff && scl_s3_ff && sda_s2_ff && !sda_s3_ff;

  always_comb
  begin
    if (off)
      nxt_pwr = PWR_SHUT;
    else if (ctrl1_ff[`C1_STBY])
      nxt_pwr = PWR_STBY;
    else
      nxt_pwr = PWR_ACT;
  end
  assign to_active = (pwr_ff != PWR_ACT) && (nxt_pwr == PWR_ACT);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_ff <= PWR_SHUT;
      analog_en_ff <= 1'b0;
      digital_en_ff <= 1'b0;
      low_power_ff <= 1'b0;
      odr_sel_ff <= 3'h0;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
      analog_en_ff <= (nxt_pwr == PWR_ACT);
      digital_en_ff <= !off;
      low_power_ff <= ctrl2_ff[`C2_LP];
      odr_sel_ff <= sleep_ff ? ctrl2_ff[`C2_SLP_ODR]
                             : ctrl2_ff[`C2_WAKE_ODR];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // I2C slave

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= I_IDLE;
      ret_ff <= I_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      host_pop_ff <= 1'b0;
    end
    else
    begin
      wr_stb_ff <= 1'b0;
      host_pop_ff <= 1'b0;
      if (off)
      begin
        st_ff <= I_IDLE;
        sda_oe_ff <= 1'b0;
        ptr_ff <= 8'h00;
      end
      else if (i2c_start)
      begin
        st_ff <= I_ADDR;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end
      else if (i2c_stop)
      begin
        st_ff <= I_IDLE;
        sda_oe_ff <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (st_ff == I_RACK)
          nack_ff <= sda_s2_ff;
        else
        begin
          sh_ff <= {sh_ff[6:0], sda_s2_ff};
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        case (st_ff)
          I_ADDR, I_REG, I_WDAT:
          begin
            if (cnt_ff == 4'h8)
            begin
              sda_oe_ff <= 1'b1;
              st_ff <= I_AACK;
              if (st_ff == I_ADDR)
              begin
                ret_ff <= sh_ff[0] ? I_RD : I_REG;
                if (sh_ff[7:1] != `SLAVE_ADDR)
                begin
                  sda_oe_ff <= 1'b0;
                  st_ff <= I_IDLE;
                end
              end
              else if (st_ff == I_REG)
              begin
                ptr_ff <= sh_ff;
                ret_ff <= I_WDAT;
              end
              else
              begin
                wr_stb_ff <= 1'b1;
                wr_addr_ff <= ptr_ff;
                wr_data_ff <= sh_ff;
                ptr_ff <= ptr_ff + 8'h01;
              end
            end
          end
          I_AACK, I_RACK:
          begin
            cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            st_ff <= (st_ff == I_AACK) ? ret_ff : I_RD;
            if ((st_ff == I_RACK) && nack_ff)
              st_ff <= I_IDLE;
            else if ((st_ff == I_RACK) || (ret_ff == I_RD))
            begin
              tx_ff <= rd_data;
              sda_oe_ff <= !rd_data[7];
              ptr_ff <= nxt_ptr;
              host_pop_ff <= (mode != BUF_OFF) && fifo_out_vld &&
                ((ptr_ff == `REG_Z8) || (ptr_ff == `REG_ZL));
            end
          end
          I_RD:
          begin
            if (cnt_ff == 4'h8)
            begin
              sda_oe_ff <= 1'b0;
              st_ff <= I_RACK;
            end
            else
            begin
              sda_oe_ff <= !tx_ff[6];
              tx_ff <= {tx_ff[6:0], 1'b0};
            end
          end
          default:
            st_ff <= st_ff;
        endcase
      end
    end
  end

  // Burst reads wrap over one sample so a buffer drain streams on
  always_comb
  begin
    if (ptr_ff == `REG_Z8)
      nxt_ptr = `REG_X8;
    else if (ptr_ff == `REG_ZL)
      nxt_ptr = `REG_XM;
    else
      nxt_ptr = ptr_ff + 8'h01;
  end

  always_comb
  begin
    rd_data = 8'h00;
    if (ptr_ff == `REG_STATUS)
      rd_data = {buf_ovf_ff, buf_wmrk_ff, fifo_cnt};
    else if (ptr_ff >= `REG_X8 && ptr_ff <= `REG_Z8)
      rd_data = view[2'(ptr_ff - `REG_X8)][11:4];
    else if (ptr_ff >= `REG_XM && ptr_ff <= `REG_ZL)
      rd_data = ptr_ff[0] ? {view[2'((ptr_ff - `REG_XM) >> 1)][3:0], 4'h0}
                          : view[2'((ptr_ff - `REG_XM) >> 1)][11:4];
    else if (ptr_ff == `REG_SYSMODE)
      rd_data = {6'h00, sleep_ff, pwr_ff == PWR_ACT};
    else if (ptr_ff == `REG_BUF_SETUP)
      rd_data = bufcfg_ff;
    else if (ptr_ff >= `REG_UOFF0 && ptr_ff <= `REG_UOFF5)
      rd_data = uoff_ff[3'(ptr_ff - `REG_UOFF0)];
    else if (ptr_ff == `REG_CTRL1)
      rd_data = ctrl1_ff;
    else if (ptr_ff == `REG_CTRL2)
      rd_data = ctrl2_ff;
    else if (ptr_ff == `REG_CTRL3)
      rd_data = ctrl3_ff;
    else if (ptr_ff == `REG_ASLP)
      rd_data = aslp_ff;
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration registers, kept across standby and active changes, cleared in shutdown

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_ff <= `CTRL1_RST;
      ctrl2_ff <= `REG_ZERO;
      ctrl3_ff <= `REG_ZERO;
      bufcfg_ff <= `REG_ZERO;
      aslp_ff <= `REG_ZERO;
    end
    else if (off)
    begin
      ctrl1_ff <= `CTRL1_RST;
      ctrl2_ff <= `REG_ZERO;
      ctrl3_ff <= `REG_ZERO;
      bufcfg_ff <= `REG_ZERO;
      aslp_ff <= `REG_ZERO;
    end
    else if (wr_stb_ff)
    begin
      case (wr_addr_ff)
        `REG_CTRL1: ctrl1_ff <= wr_data_ff;
        `REG_CTRL2: ctrl2_ff <= wr_data_ff;
        `REG_CTRL3: ctrl3_ff <= wr_data_ff;
        `REG_BUF_SETUP: bufcfg_ff <= wr_data_ff;
        `REG_ASLP: aslp_ff <= wr_data_ff;
        default: ctrl1_ff <= ctrl1_ff;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Trim, offsets and per-axis data path

  assign raw_a[0] = raw_x;
  assign raw_a[1] = raw_y;
  assign raw_a[2] = raw_z;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      trim_ok_ff <= 1'b0;
    else if (trim_valid)
      trim_ok_ff <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      smp_new_ff <= 1'b0;
    else
      smp_new_ff <= raw_valid && trim_ok_ff && (pwr_ff == PWR_ACT);
  end

  genvar i;
  for (i = 0; i < 6; i++)
  begin : g_uoff
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        uoff_ff[i] <= `REG_ZERO;
      else if (off)
        uoff_ff[i] <= `REG_ZERO;
      else if (wr_stb_ff && wr_addr_ff == `REG_UOFF0 + 8'(i))
        uoff_ff[i] <= wr_data_ff;
    end
  end

  for (i = 0; i < 3; i++)
  begin : g_axis
    logic signed [21:0] prod;
    logic signed [17:0] sum;
    logic signed [17:0] scaled;
    always_comb
    begin
      prod = raw_a[i] * gain_ff[i];
      sum = 18'(raw_a[i]) + 18'(prod >>> 7) + 18'(toff_ff[i])
          + 18'(signed'({uoff_ff[2*i], uoff_ff[2*i+1][7:4]}));
      scaled = sum >>> ctrl1_ff[`C1_FS];
      if (scaled > 18'sd2047)
        corr[i] = 12'sh7ff;
      else if (scaled < -18'sd2048)
        corr[i] = 12'sh800;
      else
        corr[i] = scaled[11:0];
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        toff_ff[i] <= 12'sh000;
        gain_ff[i] <= 8'sh00;
        smp_ff[i] <= 12'sh000;
      end
      else
      begin
        if (trim_valid && !trim_ok_ff)
        begin
          toff_ff[i] <= (i == 0) ? trim_off_x
                      : (i == 1) ? trim_off_y : trim_off_z;
          gain_ff[i] <= (i == 0) ? trim_gain_x
                      : (i == 1) ? trim_gain_y : trim_gain_z;
        end
        if (raw_valid && trim_ok_ff && (pwr_ff == PWR_ACT))
          smp_ff[i] <= corr[i];
      end
    end
    assign view[i] = (mode == BUF_OFF) ? smp_ff[i]
                   : fifo_head[FW-1-`SMP_W*i -: `SMP_W];
  end

  //////////////////////////////////////////////////////////////////////
  // Sample buffer

  always_comb
  begin
    case (bufcfg_ff[`BS_MODE])
      2'h1: mode = BUF_CIRC;
      2'h2: mode = BUF_FILL;
      default: mode = BUF_OFF;
    endcase
  end
  assign wm = bufcfg_ff[`BS_WMRK];
  assign fifo_in_vld = smp_new_ff && (mode != BUF_OFF);
  assign fifo_out_rdy = host_pop_ff || ((mode == BUF_CIRC) && fifo_in_vld
                        && (fifo_cnt == 6'(`BUF_DEPTH)));
  assign flush = off || to_active || (mode == BUF_OFF)
              || (slp_edge_ff && !ctrl3_ff[`C3_GATE]);

  sample_fifo #(
    .WIDTH(FW),
    .DEPTH(`BUF_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(fifo_in_vld),
    .in_ready(fifo_in_rdy),
    .in_data({smp_ff[0], smp_ff[1], smp_ff[2]}),
    .out_valid(fifo_out_vld),
    .out_ready(fifo_out_rdy),
    .out_data(fifo_head),
    .count(fifo_cnt)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_ovf_ff <= 1'b0;
      buf_wmrk_ff <= 1'b0;
    end
    else if (flush)
    begin
      buf_ovf_ff <= 1'b0;
      buf_wmrk_ff <= 1'b0;
    end
    else
    begin
      if (fifo_in_vld && (!fifo_in_rdy || mode == BUF_CIRC)
          && fifo_cnt == 6'(`BUF_DEPTH))
        buf_ovf_ff <= 1'b1;
      else if (fifo_cnt == 6'(`BUF_DEPTH) && mode == BUF_FILL)
        buf_ovf_ff <= 1'b1;
      else if (host_pop_ff)
        buf_ovf_ff <= 1'b0;
      buf_wmrk_ff <= (wm != 6'h0) && (fifo_cnt >= wm);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Auto-wake and sleep

  assign wake_hit = |(wake_evt & ctrl3_ff[`C3_WAKE_EN]);
  assign keep_awake = wake_hit || (ctrl3_ff[`C3_BUF_IE] &&
                      (buf_wmrk_ff || host_pop_ff));
  assign tick = (tick_ff == 24'(SLEEP_TICK_CYC - 1));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_ff <= 24'h0;
    else if (tick || off)
      tick_ff <= 24'h0;
    else
      tick_ff <= tick_ff + 24'h1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_ff <= 1'b0;
      slp_cnt_ff <= 8'h00;
      slp_edge_ff <= 1'b0;
    end
    else
    begin
      slp_edge_ff <= 1'b0;
      if (off || to_active)
      begin
        sleep_ff <= 1'b0;
        slp_cnt_ff <= 8'h00;
      end
      else if (sleep_ff)
      begin
        if (wake_hit || !ctrl2_ff[`C2_ASLP_EN])
        begin
          sleep_ff <= 1'b0;
          slp_edge_ff <= 1'b1;
          slp_cnt_ff <= 8'h00;
        end
      end
      else if (!ctrl2_ff[`C2_ASLP_EN] || pwr_ff != PWR_ACT || keep_awake)
        slp_cnt_ff <= 8'h00;
      else if (tick)
      begin
        if (slp_cnt_ff == aslp_ff)
        begin
          sleep_ff <= 1'b1;
          slp_edge_ff <= 1'b1;
        end
        else
          slp_cnt_ff <= slp_cnt_ff + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence sleep_entry;
    !sleep_ff ##1 sleep_ff;
  endsequence

  shut_quiet_a: assert property (
    off |=> !analog_en_ff && !digital_en_ff && !sda_oe_ff)
    else $error("shutdown left a block running");
  stby_dark_a: assert property (
    pwr_ff == PWR_STBY |-> !analog_en_ff && digital_en_ff)
    else $error("standby power state wrong");
  act_on_a: assert property (
    !off && !ctrl1_ff[`C1_STBY] |=> analog_en_ff && pwr_ff == PWR_ACT)
    else $error("active power state wrong");
  stby_keep_a: assert property (
    (pwr_ff == PWR_ACT && !wr_stb_ff) ##1 pwr_ff == PWR_STBY
    |-> $stable(bufcfg_ff) && $stable(ctrl2_ff) && $stable(ctrl3_ff))
    else $error("register changed entering standby");
  wake_flush_a: assert property (
    to_active |=> fifo_cnt == 6'h0 && !buf_ovf_ff && !sleep_ff)
    else $error("flagged state kept entering active");
  trim_first_a: assert property (
    smp_new_ff |-> $past(trim_ok_ff) && trim_ok_ff)
    else $error("sample taken before trim load");
  fill_hold_a: assert property (
    mode == BUF_FILL && fifo_cnt == 6'(`BUF_DEPTH) && !host_pop_ff && !flush
    |=> fifo_cnt == 6'(`BUF_DEPTH) && buf_ovf_ff)
    else $error("fill mode lost or overflow missing");
  circ_over_a: assert property (
    mode == BUF_CIRC && fifo_cnt == 6'(`BUF_DEPTH) && fifo_in_vld
    && !host_pop_ff && !flush |=> fifo_cnt == 6'(`BUF_DEPTH) && buf_ovf_ff)
    else $error("circular overwrite failed");
  wmrk_hit_a: assert property (
    mode != BUF_OFF && wm != 6'h0 && fifo_cnt >= wm && !flush
    |=> buf_wmrk_ff)
    else $error("watermark not flagged");
  lp_follow_a: assert property (
    $rose(ctrl2_ff[`C2_LP]) |=> low_power_ff)
    else $error("low power bit not applied");
  wake_up_a: assert property (
    sleep_ff && wake_hit && !off |=> !sleep_ff ##1 odr_sel_ff ==
    $past(ctrl2_ff[`C2_WAKE_ODR]))
    else $error("wake event ignored");
  gate_drop_a: assert property (
    sleep_entry ##0 !ctrl3_ff[`C3_GATE] |-> ##[1:3] fifo_cnt == 6'h0)
    else $error("ungated buffer kept over sleep");
  no_buf_wake_a: assert property (
    sleep_ff && !wake_hit && ctrl2_ff[`C2_ASLP_EN] && !off && !to_active
    |=> sleep_ff)
    else $error("non-wake source woke device");
endmodule
`default_nettype wire

//--- accel_regs.svh
// Register map, field ranges, reset values and timing counts.
// Included by the core; definitions only.
`ifndef ACCEL_REGS_SVH
`define ACCEL_REGS_SVH
`define SLAVE_ADDR 7'h1d
`define REG_STATUS 8'h00
`define REG_X8 8'h01
`define REG_Y8 8'h02
`define REG_Z8 8'h03
`define REG_XM 8'h04
`define REG_ZL 8'h09
`define REG_SYSMODE 8'h0c
`define REG_BUF_SETUP 8'h13
`define REG_UOFF0 8'h30
`define REG_UOFF5 8'h35
`define REG_CTRL1 8'h38
`define REG_CTRL2 8'h39
`define REG_CTRL3 8'h3a
`define REG_ASLP 8'h3b
`define CTRL1_RST 8'h01
`define REG_ZERO 8'h00
`define C1_STBY 0
`define C1_FS 2:1
`define C2_LP 0
`define C2_WAKE_ODR 3:1
`define C2_SLP_ODR 6:4
`define C2_ASLP_EN 7
`define C3_WAKE_EN 4:0
`define C3_BUF_IE 5
`define C3_GATE 7
`define BS_MODE 7:6
`define BS_WMRK 5:0
`define BUF_DEPTH 32
`define SMP_W 12
`define SLEEP_TICK_US 1000
`define REF_CLK_MHZ 10
`define SLEEP_TICK_CYC (`SLEEP_TICK_US * `REF_CLK_MHZ)
`endif

//--- accel_pkg.sv
// Types shared by the accelerometer core.
// Assumes accel_regs.svh supplies the numeric constants.
package accel_pkg;
  typedef enum logic [1:0] {BUF_OFF, BUF_CIRC, BUF_FILL} buf_mode_t;
  typedef enum logic [1:0] {PWR_SHUT, PWR_STBY, PWR_ACT} pwr_mode_t;
  typedef enum logic [2:0]
  {
    I_IDLE, I_ADDR, I_AACK, I_REG, I_WDAT, I_RD, I_RACK
  } i2c_st_t;
endpackage

//--- i2c_host.sv
// Host model: I2C master driving the block's bus pins.
// Assumes an open-drain data wire pulled high by the bench.
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
  // Timebase
  input wire logic ref_clk,
  // Bus
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial scl = 1'h1;
  initial sda_low = 1'h0;
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    tk(2);
    sda_low = ~b;
    tk(2);
    scl = 1'h1;
    tk(4);
    r = sda;
    scl = 1'h0;
  endtask
  // Start when s is 1, stop when s is 0
  task automatic cond(input logic s);
    tk(2);
    sda_low = ~s;
    tk(2);
    scl = 1'h1;
    tk(4);
    sda_low = s;
    tk(4);
    if (s)
      scl = 1'h0;
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] q,
                    output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'h1, a);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] v,
                    output logic nak);
    logic [7:0] q;
    logic a0, a1, a2;
    cond(1'h1);
    xb(8'h3a, q, a0);
    xb(ra, q, a1);
    xb(v, q, a2);
    cond(1'h0);
    nak = a0 | a1 | a2;
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] q);
    logic a;
    cond(1'h1);
    xb(8'h3a, q, a);
    xb(ra, q, a);
    cond(1'h1);
    xb(8'h3b, q, a);
    xb(8'hff, q, a);
    cond(1'h0);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Bench for accel_core: bus, scaling, buffer, power and sleep.
// Assumes i2c_host as bus master; trim offset fixed at 16 counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic en_pin = 1'h1;
  logic raw_valid = 1'h0;
  logic trim_valid = 1'h0;
  logic signed [13:0] raw = 14'h0;
  logic signed [11:0] toff = 12'h010;
  logic signed [7:0] tg = 8'h0;
  logic [4:0] wake_evt = 5'h0;
  logic sda_oe, analog_en, digital_en, low_power, sleeping;
  logic buf_wmrk, buf_ovf, nak;
  logic [2:0] odr_sel;
  logic [7:0] q;
  int n_errors = 0;
  int compares = 0;
  wire scl, sda_low, sda;
  assign sda = ~(sda_oe | sda_low);
  always #50 ref_clk = ~ref_clk;
  accel_core #(.SLEEP_TICK_CYC(4)) accel_core_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .en_pin(en_pin), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .trim_valid(trim_valid), .trim_off_x(toff),
    .trim_off_y(toff), .trim_off_z(toff), .trim_gain_x(tg),
    .trim_gain_y(tg), .trim_gain_z(tg), .raw_valid(raw_valid),
    .raw_x(raw), .raw_y(raw), .raw_z(raw), .wake_evt(wake_evt),
    .analog_en(analog_en), .digital_en(digital_en),
    .low_power(low_power), .sleeping(sleeping), .odr_sel(odr_sel),
    .buf_wmrk(buf_wmrk), .buf_ovf(buf_ovf));
  i2c_host i2c_host_i (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low),
    .sda(sda));
  task automatic chk(input string w, input logic [7:0] s,
                     input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", w, e, s);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] v);
    i2c_host_i.wr(ra, v, nak);
    chk("ack", 8'(nak), 8'h0);
  endtask
  // Sample j is 16*j once trim is added and reads back as j in X8
  task automatic push(input int k, input int n);
    for (int j = k; j < k + n; j++)
    begin
      raw = 14'(16 * j - 16);
      raw_valid = 1'h1;
      cyc(1);
      raw_valid = 1'h0;
      cyc(3);
    end
  endtask
  task automatic t_modes();
    chk("dig", 8'(digital_en), 8'h1);
    chk("ana", 8'(analog_en), 8'h0);
    wr(8'h38, 8'h00);
    chk("ana", 8'(analog_en), 8'h1);
    push(5, 1);
    i2c_host_i.rd(8'h01, q);
    chk("untrim", q, 8'h00);
    trim_valid = 1'h1;
    cyc(1);
    trim_valid = 1'h0;
  endtask
  task automatic t_scale();
    push(10, 1);
    i2c_host_i.rd(8'h01, q);
    chk("x8", q, 8'h0a);
    i2c_host_i.rd(8'h04, q);
    chk("xm", q, 8'h0a);
    wr(8'h38, 8'h04);
    push(10, 1);
    i2c_host_i.rd(8'h01, q);
    chk("x8g", q, 8'h02);
    wr(8'h38, 8'h00);
    wr(8'h30, 8'h01);
    push(10, 1);
    i2c_host_i.rd(8'h01, q);
    chk("uoff", q, 8'h0b);
    wr(8'h30, 8'h00);
  endtask
  task automatic t_fill();
    wr(8'h13, 8'h84);
    push(1, 3);
    chk("wm", 8'(buf_wmrk), 8'h0);
    push(4, 1);
    chk("wm", 8'(buf_wmrk), 8'h1);
    push(5, 30);
    chk("ovf", 8'(buf_ovf), 8'h1);
    i2c_host_i.rd(8'h00, q);
    chk("stat", q, 8'he0);
    i2c_host_i.rd(8'h01, q);
    chk("head", q, 8'h01);
  endtask
  task automatic t_circ();
    wr(8'h13, 8'h00);
    wr(8'h13, 8'h41);
    push(0, 33);
    chk("ovf", 8'(buf_ovf), 8'h1);
    i2c_host_i.rd(8'h01, q);
    chk("head", q, 8'h01);
    wr(8'h38, 8'h01);
    i2c_host_i.rd(8'h13, q);
    chk("setup", q, 8'h41);
    wr(8'h38, 8'h00);
    i2c_host_i.rd(8'h00, q);
    chk("stat", q, 8'h00);
  endtask
  task automatic t_sleep();
    wr(8'h13, 8'h00);
    wr(8'h3a, 8'h01);
    wr(8'h3b, 8'h02);
    wr(8'h39, 8'hb3);
    cyc(20);
    chk("slp", 8'(sleeping), 8'h1);
    chk("odr", 8'(odr_sel), 8'h3);
    chk("lp", 8'(low_power), 8'h1);
    i2c_host_i.rd(8'h0c, q);
    chk("mode", q, 8'h03);
    wake_evt = 5'h02;
    cyc(1);
    wake_evt = 5'h00;
    cyc(4);
    chk("slp", 8'(sleeping), 8'h1);
    wake_evt = 5'h01;
    cyc(1);
    wake_evt = 5'h00;
    cyc(4);
    chk("slp", 8'(sleeping), 8'h0);
    chk("odr", 8'(odr_sel), 8'h1);
    wr(8'h39, 8'h33);
    wr(8'h3a, 8'h21);
    wr(8'h13, 8'h41);
    push(1, 1);
    wr(8'h39, 8'hb3);
    cyc(20);
    chk("awake", 8'(sleeping), 8'h0);
  endtask
  task automatic t_off();
    en_pin = 1'h0;
    cyc(4);
    chk("dig", 8'(digital_en), 8'h0);
    chk("ana", 8'(analog_en), 8'h0);
    i2c_host_i.rd(8'h38, q);
    chk("off", q, 8'hff);
  endtask
  initial
  begin
    cyc(10);
    rst_n = 1'h1;
    cyc(10);
    t_modes();
    t_scale();
    t_fill();
    t_circ();
    t_sleep();
    t_off();
    results();
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
